// *** afb_pkg.sv ***
// package for the flash bus host controller
package afb_pkg;
    localparam int ADDR_W          = 18;
    localparam int DATA_W          = 16;
    localparam int CLK_PERIOD_PS   = 25000;
    // timing figures in ns, counts derived from the 25 ns clock
    localparam int MIN_RESET_PULSE_NS  = 500;
    localparam int RESET_RECOVERY_A_NS = 50;
    localparam int RESET_RECOVERY_B_NS = 0;
    localparam int READ_ACCESS_NS      = 45;
    localparam int WRITE_PULSE_NS      = 30;
    localparam int GLITCH_NS           = 5;
    localparam int RESET_CYC   = (MIN_RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOV_NS    = (RESET_RECOVERY_A_NS > RESET_RECOVERY_B_NS) ? RESET_RECOVERY_A_NS
                                                                          : RESET_RECOVERY_B_NS;
    localparam int RECOV_CYC_R = (RECOV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOV_CYC   = (RECOV_CYC_R < 1) ? 1 : RECOV_CYC_R;
    localparam int READ_CYC_R  = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_CYC    = (READ_CYC_R < 1) ? 1 : READ_CYC_R;
    localparam int WR_CYC_R    = (WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // strobes must not be shorter than the glitch width the device rejects
    localparam int WR_CYC      = (WR_CYC_R * CLK_PERIOD_PS < GLITCH_NS * 1000) ? 1 : WR_CYC_R;
    localparam int CNT_W       = 8;

    typedef enum logic [2:0] {
        AFB_IDLE   = 3'b000,
        AFB_RST    = 3'b001,
        AFB_RECOV  = 3'b010,
        AFB_WAITRB = 3'b011,
        AFB_RD     = 3'b100,
        AFB_WR     = 3'b101,
        AFB_WREND  = 3'b110
    } afb_state_t;

    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              reset_unprotect_n;
        logic              byte_mode_n;
        logic [ADDR_W-1:0] addr_in;
        logic              top_data_or_low_addr;
        logic [DATA_W-1:0] dout;
        logic              data_oe_n;
    } afb_pins_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic              hw_reset;
        logic              byte_mode;
        logic [ADDR_W-1:0] addr;
        logic              low_addr;
        logic [DATA_W-1:0] wdata;
    } afb_req_t;

    typedef struct packed {
        afb_state_t        st;
        logic [CNT_W-1:0]  cnt;
        afb_pins_t         pins;
        logic [DATA_W-1:0] rdata;
        logic              done;
    } afb_regs_t;
endpackage : afb_pkg

// *** afb_host.sv ***
// host controller driving an asynchronous parallel flash bus
`timescale 1ns/1ps
module afb_host
    import afb_pkg::*;
(
    input  wire logic                      CLK_I,
    input  wire logic                      RESET_I,
    input  wire afb_pkg::afb_req_t         REQ_I,
    output logic                           READY_O,
    output logic                           DONE_O,
    output logic [afb_pkg::DATA_W-1:0]     RDATA_O,
    output logic                           BUSY_O,
    output afb_pkg::afb_pins_t             PINS_O,
    input  wire logic [afb_pkg::DATA_W-1:0] DATA_I,
    input  wire logic                      READY_BUSY_OD_I
);
    import afb_pkg::*;

    afb_regs_t r;
    afb_regs_t next_r;
    logic      dev_busy;

    // ************************************************************
    // status outputs
    // ************************************************************
    assign dev_busy = ~READY_BUSY_OD_I;
    assign READY_O  = (r.st == AFB_IDLE) && !dev_busy;
    assign DONE_O   = r.done;
    assign RDATA_O  = r.rdata;
    assign BUSY_O   = dev_busy;
    assign PINS_O   = r.pins;

    // ************************************************************
    // bus sequencer
    // ************************************************************
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.st)
            AFB_IDLE: begin
                next_r.pins.ce_n      = 1'b1;
                next_r.pins.oe_n      = 1'b1;
                next_r.pins.we_n      = 1'b1;
                next_r.pins.data_oe_n = 1'b1;
                if (REQ_I.hw_reset) begin
                    next_r.st                     = AFB_RST;
                    next_r.cnt                    = CNT_W'(RESET_CYC);
                    next_r.pins.reset_unprotect_n = 1'b0;
                end else if (!dev_busy && (REQ_I.rd || REQ_I.wr)) begin
                    next_r.pins.byte_mode_n          = REQ_I.byte_mode;
                    next_r.pins.addr_in              = REQ_I.addr;
                    next_r.pins.top_data_or_low_addr = REQ_I.byte_mode ? 1'b0 : REQ_I.low_addr;
                    next_r.pins.ce_n                 = 1'b0;
                    if (REQ_I.rd) begin
                        next_r.st        = AFB_RD;
                        next_r.cnt       = CNT_W'(READ_CYC);
                        next_r.pins.oe_n = 1'b0;
                    end else begin
                        next_r.st             = AFB_WR;
                        next_r.cnt            = CNT_W'(WR_CYC);
                        next_r.pins.we_n      = 1'b0;
                        next_r.pins.dout      = REQ_I.wdata;
                        next_r.pins.data_oe_n = 1'b0;
                    end
                end
            end
            AFB_RST: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == CNT_W'(1)) begin
                    next_r.st                     = AFB_RECOV;
                    next_r.cnt                    = CNT_W'(RECOV_CYC);
                    next_r.pins.reset_unprotect_n = 1'b1;
                end
            end
            AFB_RECOV: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == CNT_W'(1)) begin
                    next_r.st = AFB_WAITRB;
                end
            end
            AFB_WAITRB: begin
                if (!dev_busy) begin
                    next_r.st   = AFB_IDLE;
                    next_r.done = 1'b1;
                end
            end
            AFB_RD: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == CNT_W'(1)) begin
                    // upper pins float in 8-bit mode
                    next_r.rdata     = r.pins.byte_mode_n ? DATA_I : {8'h00, DATA_I[7:0]};
                    next_r.pins.ce_n = 1'b1;
                    next_r.pins.oe_n = 1'b1;
                    next_r.st        = AFB_IDLE;
                    next_r.done      = 1'b1;
                end
            end
            AFB_WR: begin
                next_r.cnt = r.cnt - 1'b1;
                if (r.cnt == CNT_W'(1)) begin
                    // both strobes rise together, data still held
                    next_r.pins.we_n = 1'b1;
                    next_r.pins.ce_n = 1'b1;
                    next_r.st        = AFB_WREND;
                end
            end
            AFB_WREND: begin
                next_r.pins.data_oe_n = 1'b1;
                next_r.st             = AFB_IDLE;
                next_r.done           = 1'b1;
            end
            default: begin
                next_r.st = AFB_IDLE;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            r                             <= '0;
            r.st                          <= AFB_IDLE;
            r.pins.ce_n                   <= 1'b1;
            r.pins.oe_n                   <= 1'b1;
            r.pins.we_n                   <= 1'b1;
            r.pins.reset_unprotect_n      <= 1'b1;
            r.pins.byte_mode_n            <= 1'b1;
            r.pins.data_oe_n              <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_write_oe_high: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.we_n |-> r.pins.oe_n) else $error("output enable low during write");
    a_no_drive_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.oe_n |-> r.pins.data_oe_n) else $error("host drives data during read");
    a_reset_pulse_len: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $rose(r.pins.reset_unprotect_n) |-> $past(!r.pins.reset_unprotect_n, RESET_CYC))
        else $error("reset pulse too short");
    a_data_held_rise: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $rose(r.pins.we_n) |-> !r.pins.data_oe_n && $stable(r.pins.dout)) else $error("data not held at strobe rise");
    a_addr_stable_wr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.we_n && $past(!r.pins.we_n) |-> $stable(r.pins.addr_in)) else $error("address moved in write");
    a_read_ctrl: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.oe_n |-> !r.pins.ce_n && r.pins.we_n) else $error("bad read control levels");
    a_recov_wait: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $rose(r.pins.reset_unprotect_n) |-> r.pins.ce_n [*2]) else $error("cycle too soon after reset");
    a_rb_gate: assert property (@(posedge CLK_I) disable iff (RESET_I)
        r.st == AFB_WAITRB && dev_busy |=> r.pins.ce_n) else $error("cycle while busy after reset");
    a_byte_low_addr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.ce_n && $past(!r.pins.ce_n) |-> $stable(r.pins.top_data_or_low_addr))
        else $error("byte select moved during a cycle");

    a_strobe_width: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $fell(r.pins.we_n) |-> !r.pins.we_n [*2])
        else $error("write strobe shorter than two cycles");

    a_strobes_fall: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $fell(r.pins.we_n) |-> $fell(r.pins.ce_n))
        else $error("enable and strobe fell apart");

    a_strobes_rise: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $rose(r.pins.we_n) |-> $rose(r.pins.ce_n))
        else $error("enable and strobe rose apart");

    a_data_driven_wr: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.we_n |-> !r.pins.data_oe_n)
        else $error("data not driven while strobe low");

    a_reset_bus_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !r.pins.reset_unprotect_n |-> r.pins.ce_n && r.pins.oe_n && r.pins.we_n)
        else $error("bus active during hardware reset");

    a_read_access: assert property (@(posedge CLK_I) disable iff (RESET_I)
        $rose(r.pins.oe_n) |-> $past(!r.pins.oe_n, 2))
        else $error("read enable shorter than access time");

    a_no_drive_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
        r.st == AFB_IDLE |-> r.pins.data_oe_n && r.pins.ce_n)
        else $error("bus not released when idle");

    // ************************************************************
    // scenario covers
    // ************************************************************
    c_read: cover property (@(posedge CLK_I) r.st == AFB_RD ##1 r.done);
    c_write: cover property (@(posedge CLK_I) r.st == AFB_WREND);
    c_reset: cover property (@(posedge CLK_I) r.st == AFB_WAITRB ##1 r.st == AFB_IDLE);
    c_byte_read: cover property (@(posedge CLK_I) r.st == AFB_RD && !r.pins.byte_mode_n ##1 r.done);
    c_busy_hold: cover property (@(posedge CLK_I) r.st == AFB_IDLE && dev_busy);
endmodule : afb_host

// *** afb_flash_model.sv ***
// behavioural flash device that answers the host controller's bus
`timescale 1ns/1ps
module afb_flash_model #(
    parameter int RB_RESET_NS = 200,
    parameter int PROG_NS     = 400
) (
    input  wire afb_pkg::afb_pins_t          pins_i,
    input  wire logic                        slow_i,
    input  wire logic                        rb_line_i,
    input  wire logic                        lockout_i,
    output logic [afb_pkg::DATA_W-1:0]       data_o,
    output logic                             rb_o,
    output int                               viol_o
);
    import afb_pkg::*;
    // ***************************************************
    // array, read path and write latches
    // ***************************************************
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last    = '0;
    logic [ADDR_W:0]   wr_addr = '0;
    logic              wr_open = 1'b0;
    logic              rd_en;
    logic              wide;
    logic [DATA_W-1:0] word;
    realtime           t_fall  = 0.0;
    initial begin
        rb_o   = 1'b1;
        viol_o = 0;
    end
    assign wide  = pins_i.byte_mode_n;
    assign rd_en = !pins_i.ce_n && !pins_i.oe_n && pins_i.we_n && pins_i.reset_unprotect_n;
    assign word  = mem[pins_i.addr_in[3:0]];
    // released pins show the inverse of the last driven value
    assign data_o[15:8] = (rd_en && wide) ? word[15:8] : ~last[15:8];
    assign data_o[7:0]  = !rd_en ? ~last[7:0] : (wide || !pins_i.top_data_or_low_addr) ? word[7:0] : word[15:8];
    always @(rd_en or word) if (rd_en) last = word;
    always @(negedge pins_i.reset_unprotect_n) rb_o = 1'b0;
    always @(posedge pins_i.reset_unprotect_n) begin
        #(RB_RESET_NS) rb_o = 1'b1;
    end
    // every block is writable while lockout_i is low: no protection and no signature store
    always @(negedge pins_i.ce_n or negedge pins_i.we_n) begin
        if (!pins_i.ce_n && !pins_i.we_n && pins_i.reset_unprotect_n && !lockout_i) begin
            wr_addr = {pins_i.addr_in, pins_i.top_data_or_low_addr};
            wr_open = 1'b1;
            t_fall  = $realtime;
        end
        if (!pins_i.ce_n && !rb_line_i) viol_o++;
        if (!pins_i.ce_n && !pins_i.we_n && !pins_i.oe_n) viol_o++;
    end
    always @(posedge pins_i.ce_n or posedge pins_i.we_n) begin
        if (wr_open) begin
            wr_open = 1'b0;
            if (pins_i.data_oe_n) viol_o++;
            // strobes shorter than the glitch width leave no trace
            if ($realtime - t_fall >= GLITCH_NS) begin
                if (wide) mem[wr_addr[4:1]] = pins_i.dout;
                else if (wr_addr[0]) mem[wr_addr[4:1]][15:8] = pins_i.dout[7:0];
                else mem[wr_addr[4:1]][7:0] = pins_i.dout[7:0];
                if (slow_i) begin
                    rb_o = 1'b0;
                    rb_o <= #(PROG_NS) 1'b1;
                end
            end
        end
    end
    // a supply drop during a program aborts it and spoils the word in flight
    always @(posedge lockout_i) begin
        if (!rb_o) begin
            mem[wr_addr[4:1]] = 'x;
            rb_o = 1'b1;
        end
    end
endmodule : afb_flash_model

// *** test_afb_host.sv ***
// self-checking bench for the flash bus host controller
`timescale 1ns/1ps
module test_afb_host;
    import afb_pkg::*;
    logic              clk = 1'b0, rst = 1'b1, other_rb = 1'b1, slow = 1'b0, lockout = 1'b0;
    logic              ready, done, busy, rb_model;
    afb_req_t          req = '0;
    logic [DATA_W-1:0] rdata, data;
    afb_pins_t         pins;
    int                viol, r, bad_count = 0, comparisons = 0;
    wire               rb_line = rb_model & other_rb;
    afb_host dut (.CLK_I(clk), .RESET_I(rst), .REQ_I(req), .READY_O(ready), .DONE_O(done), .RDATA_O(rdata),
                  .BUSY_O(busy), .PINS_O(pins), .DATA_I(data), .READY_BUSY_OD_I(rb_line));
    afb_flash_model flash (.pins_i(pins), .slow_i(slow), .rb_line_i(rb_line), .data_o(data), .rb_o(rb_model),
                           .lockout_i(lockout), .viol_o(viol));
    always #12.5 clk = ~clk;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic give_verdict;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // one request: kind 0 read, 1 write, 2 hardware reset; rst_low counts cycles with the reset pin low
    task automatic run(input int kind, input logic [ADDR_W-1:0] a, input logic lo, input logic wide,
                       input logic [DATA_W-1:0] wd, output int rst_low);
        int n;
        n = 0;
        rst_low = 0;
        while (!ready && n < 4000) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        req <= afb_req_t'{rd: kind == 0, wr: kind == 1, hw_reset: kind == 2, byte_mode: wide, addr: a,
                          low_addr: lo, wdata: wd};
        @(posedge clk);
        req <= '0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            rst_low += int'(!pins.reset_unprotect_n);
        end while (!done && n < 4000);
        check("done", 1'b1, done);
    endtask : run
    task automatic scen_word_byte;
        run(1, 18'h00003, 1'b0, 1'b1, 16'hBEEF, r);
        run(0, 18'h00003, 1'b0, 1'b1, 16'h0000, r);
        check("word read", 16'hBEEF, rdata);
        run(0, 18'h00003, 1'b1, 1'b0, 16'h0000, r);
        check("high byte", 16'h00BE, rdata);
        run(1, 18'h00003, 1'b0, 1'b0, 16'h0042, r);
        run(0, 18'h00003, 1'b0, 1'b1, 16'h0000, r);
        check("merged word", 16'hBE42, rdata);
    endtask : scen_word_byte
    task automatic scen_shared_busy;
        @(posedge clk);
        other_rb <= 1'b0;
        req.rd   <= 1'b1;
        repeat (4) @(negedge clk);
        check("ready busy", 2'b01, {ready, busy});
        check("no cycle while busy", 2'b10, {pins.ce_n, done});
        @(posedge clk);
        req.rd   <= 1'b0;
        other_rb <= 1'b1;
    endtask : scen_shared_busy
    task automatic scen_program;
        slow = 1'b1;
        run(1, 18'h00005, 1'b0, 1'b1, 16'h1234, r);
        check("busy after program", 1'b1, busy);
        slow = 1'b0;
        run(0, 18'h00005, 1'b0, 1'b1, 16'h0000, r);
        check("read after program", 16'h1234, rdata);
    endtask : scen_program
    task automatic scen_lockout;
        lockout = 1'b1;
        run(1, 18'h00003, 1'b0, 1'b1, 16'h5555, r);
        lockout = 1'b0;
        run(0, 18'h00003, 1'b0, 1'b1, 16'h0000, r);
        check("locked write ignored", 16'hBE42, rdata);
    endtask : scen_lockout
    task automatic scen_hw_reset;
        run(2, 18'h00000, 1'b0, 1'b1, 16'h0000, r);
        check("reset pulse long", 1'b1, r >= RESET_CYC);
        check("line released", 1'b1, rb_line);
        run(0, 18'h00003, 1'b0, 1'b1, 16'h0000, r);
        check("read after reset", 16'hBE42, rdata);
    endtask : scen_hw_reset
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("idle pins", 5'h1F, {pins.ce_n, pins.oe_n, pins.we_n, pins.data_oe_n, pins.reset_unprotect_n});
        scen_word_byte();
        scen_shared_busy();
        scen_program();
        scen_lockout();
        scen_hw_reset();
        check("bus order faults", 0, viol);
        give_verdict();
    end
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end
endmodule : test_afb_host
